// ==== src/vca_pkg.sv ====
// Package for the VC0 arbitration configuration register bank.
// Assumes a 32-bit AHB-Lite slave on a single 40 MHz clock.
package vca_pkg;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [11:0] VC_PORT_STATUS_OFF = 12'h14c;
   localparam logic [11:0] VC0_RES_CAP_OFF = 12'h150;
   localparam logic [11:0] VC0_RES_CTL_OFF = 12'h154;
   localparam logic [11:0] VC_ARB_ENTRY_OFF = 12'h170;
   localparam logic [11:0] PORT_ARB_ENTRY_OFF = 12'h174;
   localparam logic [11:0] VC_ARB_LOAD_OFF = 12'h178;
   localparam logic [11:0] PRESET_MAP_OFF = 12'h17c;
   localparam logic [11:0] ADDR_MASK = 12'hffc;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int VC_TBL_STATUS_BIT = 16;
   localparam int LOAD_PORT_TBL_BIT = 16;
   localparam int PORT_ARB_SEL_LSB = 17;
   localparam int CHAN_ID_LSB = 24;
   localparam int CHAN_EN_BIT = 31;
   localparam int LOAD_VC_TBL_BIT = 0;
   localparam int TIME_SLOTS_LSB = 16;
   localparam int TBL_OFFSET_LSB = 24;

   // ----------------------------------------------------------------
   // Reset and fixed values
   // ----------------------------------------------------------------
   localparam logic [7:0] PORT_ARB_CAP_RST = 8'h09;
   localparam logic [6:0] MAX_TIME_SLOTS_RST = 7'h7f;
   localparam logic [7:0] PORT_TBL_OFFSET_RST = 8'h04;
   localparam logic [7:0] TC_MAP_RST = 8'hff;
   localparam logic [2:0] CHAN_ID_VAL = 3'h0;
   localparam logic CHAN_EN_RST = 1'b1;

   // ----------------------------------------------------------------
   // Timing: table load time in ns, and its cycle count at 40 MHz
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int TBL_LOAD_NS = 200;
   localparam int TBL_LOAD_CYC_I = (TBL_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] TBL_LOAD_CYC = 4'(TBL_LOAD_CYC_I);

   // ----------------------------------------------------------------
   // Port arbitration schemes
   // ----------------------------------------------------------------
   localparam logic [2:0] PARB_DEFAULT = 3'h0;
   localparam logic [2:0] PARB_WRR = 3'h3;

   typedef enum logic [1:0] {VCA_HTRANS_IDLE, VCA_HTRANS_BUSY, VCA_HTRANS_NONSEQ,
      VCA_HTRANS_SEQ} vca_htrans_t;

   typedef struct packed {
      logic [7:0] tc_map;
      logic [2:0] port_arb_sel;
      logic chan_en;
   } vca_ctrl_t;

   typedef struct packed {
      logic vc_tbl_load;
      logic port_tbl_load;
   } vca_load_t;

endpackage : vca_pkg

// ==== src/vca_tbl_loader.sv ====
// Table loader: counts out a fixed load time after a load request.
// Assumes the request is a one-cycle pulse on hclk.
`timescale 1ns/1ps
module vca_tbl_loader (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Request and status
   input wire logic start,
   output logic busy,
   output logic done
);

   typedef enum logic {VCA_LD_IDLE, VCA_LD_RUN} vca_ld_state_t;

   vca_ld_state_t state_ff;
   logic [3:0] cnt_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= VCA_LD_IDLE;
         cnt_ff <= 4'h0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state_ff)
            VCA_LD_IDLE: begin
               if (start) begin
                  state_ff <= VCA_LD_RUN;
                  cnt_ff <= vca_pkg::TBL_LOAD_CYC;
               end
            end
            VCA_LD_RUN: begin
               if (cnt_ff == 4'h1) begin
                  state_ff <= VCA_LD_IDLE;
                  done <= 1'b1;
               end
               cnt_ff <= cnt_ff - 4'h1;
            end
            default: state_ff <= VCA_LD_IDLE;
         endcase
      end
   end

   assign busy = (state_ff == VCA_LD_RUN);

endmodule : vca_tbl_loader

// ==== src/vca_regs.sv ====
// VC0 arbitration configuration registers behind an AHB-Lite slave.
// Assumes single-word transfers; one clock, hclk, 40 MHz.
// What this block does
// - Table write sets VC table status bit
// - Status clears when table load finishes
// - Load VC table bit triggers load, reads zero
// - Port arbitration capability reads fixed 09h
// - Time-based scheme never offered on VC0
// - Packet-switching-only bit reads zero
// - Snoop rejection bit reads zero
// - Maximum time slots reads 7Fh
// - Port table offset reads 04h
// - Traffic class map writable, resets FFh
// - Map default overridable by management preset
// - Load port table bit triggers load, reads zero
// - Port arbitration select accepts 000b, 011b only
// - Channel identifier reads fixed 000b
// - Channel enable writable, resets to one
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
module vca_regs (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Management preset of the traffic class map
   input wire logic preset_map_valid,
   input wire logic [7:0] preset_map,
   // Configuration to the arbiter
   output vca_pkg::vca_ctrl_t ctrl,
   output vca_pkg::vca_load_t load_pulse,
   output logic vc_tbl_wr,
   output logic [31:0] vc_tbl_wdata,
   output logic port_tbl_wr,
   output logic [31:0] port_tbl_wdata
);

   // ----------------------------------------------------------------
   // Address phase capture
   // ----------------------------------------------------------------
   logic wr_ff;
   logic rd_ff;
   logic [11:0] addr_ff;
   logic valid_req;

   assign valid_req = hsel && hready && (htrans == 2'(vca_pkg::VCA_HTRANS_NONSEQ)
      || htrans == 2'(vca_pkg::VCA_HTRANS_SEQ));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         addr_ff <= 12'h000;
      end else begin
         wr_ff <= valid_req && hwrite;
         rd_ff <= valid_req && !hwrite;
         if (valid_req) begin
            addr_ff <= haddr & vca_pkg::ADDR_MASK;
         end
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction : hit

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   logic wr_ctl;
   logic wr_vc_entry;
   logic wr_port_entry;
   logic wr_vc_load;
   logic wr_preset;

   assign wr_ctl = wr_ff && hit(addr_ff, vca_pkg::VC0_RES_CTL_OFF);
   assign wr_vc_entry = wr_ff && hit(addr_ff, vca_pkg::VC_ARB_ENTRY_OFF);
   assign wr_port_entry = wr_ff && hit(addr_ff, vca_pkg::PORT_ARB_ENTRY_OFF);
   assign wr_vc_load = wr_ff && hit(addr_ff, vca_pkg::VC_ARB_LOAD_OFF);
   assign wr_preset = wr_ff && hit(addr_ff, vca_pkg::PRESET_MAP_OFF);

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   logic [7:0] tc_map_ff;
   logic [2:0] port_arb_sel_ff;
   logic chan_en_ff;
   logic [2:0] nxt_port_arb_sel;

   always_comb begin
      nxt_port_arb_sel = hwdata[vca_pkg::PORT_ARB_SEL_LSB +: 3];
      if (nxt_port_arb_sel != vca_pkg::PARB_WRR) begin
         nxt_port_arb_sel = vca_pkg::PARB_DEFAULT;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tc_map_ff <= vca_pkg::TC_MAP_RST;
         port_arb_sel_ff <= vca_pkg::PARB_DEFAULT;
         chan_en_ff <= vca_pkg::CHAN_EN_RST;
      end else begin
         if (wr_ctl) begin
            tc_map_ff <= hwdata[7:0];
            port_arb_sel_ff <= nxt_port_arb_sel;
            chan_en_ff <= hwdata[vca_pkg::CHAN_EN_BIT];
         end else if (wr_preset) begin
            tc_map_ff <= hwdata[7:0];
         end else if (preset_map_valid) begin
            tc_map_ff <= preset_map;
         end
      end
   end

   assign ctrl.tc_map = tc_map_ff;
   assign ctrl.port_arb_sel = port_arb_sel_ff;
   assign ctrl.chan_en = chan_en_ff;

   // ----------------------------------------------------------------
   // Load strobes and table writes
   // ----------------------------------------------------------------
   logic vc_load_ff;
   logic port_load_ff;
   logic [31:0] tbl_wdata_ff;
   logic vc_tbl_wr_ff;
   logic port_tbl_wr_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vc_load_ff <= 1'b0;
         port_load_ff <= 1'b0;
         vc_tbl_wr_ff <= 1'b0;
         port_tbl_wr_ff <= 1'b0;
         tbl_wdata_ff <= 32'h0000_0000;
      end else begin
         vc_load_ff <= wr_vc_load && hwdata[vca_pkg::LOAD_VC_TBL_BIT];
         port_load_ff <= wr_ctl && hwdata[vca_pkg::LOAD_PORT_TBL_BIT];
         vc_tbl_wr_ff <= wr_vc_entry;
         port_tbl_wr_ff <= wr_port_entry;
         if (wr_vc_entry || wr_port_entry) begin
            tbl_wdata_ff <= hwdata;
         end
      end
   end

   assign load_pulse.vc_tbl_load = vc_load_ff;
   assign load_pulse.port_tbl_load = port_load_ff;
   assign vc_tbl_wr = vc_tbl_wr_ff;
   assign vc_tbl_wdata = tbl_wdata_ff;
   assign port_tbl_wr = port_tbl_wr_ff;
   assign port_tbl_wdata = tbl_wdata_ff;

   // ----------------------------------------------------------------
   // VC table loader and status flag
   // ----------------------------------------------------------------
   logic vc_load_done;
   logic vc_tbl_status_ff;

   vca_tbl_loader u_vc_loader (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(vc_load_ff),
      .busy(),
      .done(vc_load_done)
   );

   // Entry write wins over a load finishing in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vc_tbl_status_ff <= 1'b0;
      end else if (wr_vc_entry) begin
         vc_tbl_status_ff <= 1'b1;
      end else if (vc_load_done) begin
         vc_tbl_status_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   logic [31:0] cap_word;
   logic [31:0] ctl_word;
   logic [31:0] stat_word;
   logic [31:0] nxt_hrdata;

   always_comb begin
      cap_word = 32'h0000_0000;
      cap_word[7:0] = vca_pkg::PORT_ARB_CAP_RST;
      cap_word[vca_pkg::TIME_SLOTS_LSB +: 7] = vca_pkg::MAX_TIME_SLOTS_RST;
      cap_word[vca_pkg::TBL_OFFSET_LSB +: 8] = vca_pkg::PORT_TBL_OFFSET_RST;
      ctl_word = 32'h0000_0000;
      ctl_word[7:0] = tc_map_ff;
      ctl_word[vca_pkg::PORT_ARB_SEL_LSB +: 3] = port_arb_sel_ff;
      ctl_word[vca_pkg::CHAN_ID_LSB +: 3] = vca_pkg::CHAN_ID_VAL;
      ctl_word[vca_pkg::CHAN_EN_BIT] = chan_en_ff;
      stat_word = 32'h0000_0000;
      stat_word[vca_pkg::VC_TBL_STATUS_BIT] = vc_tbl_status_ff;
      nxt_hrdata = 32'h0000_0000;
      if (hit(haddr & vca_pkg::ADDR_MASK, vca_pkg::VC_PORT_STATUS_OFF)) begin
         nxt_hrdata = stat_word;
      end else if (hit(haddr & vca_pkg::ADDR_MASK, vca_pkg::VC0_RES_CAP_OFF)) begin
         nxt_hrdata = cap_word;
      end else if (hit(haddr & vca_pkg::ADDR_MASK, vca_pkg::VC0_RES_CTL_OFF)) begin
         nxt_hrdata = ctl_word;
      end else if (hit(haddr & vca_pkg::ADDR_MASK, vca_pkg::VC_ARB_LOAD_OFF)) begin
         nxt_hrdata = 32'h0000_0000;
      end else if (hit(haddr & vca_pkg::ADDR_MASK, vca_pkg::PRESET_MAP_OFF)) begin
         nxt_hrdata = {24'h0, tc_map_ff};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (valid_req && !hwrite) begin
         hrdata <= nxt_hrdata;
      end
   end

endmodule : vca_regs

// ==== verif/vca_regs_assertions.sv ====
// Checker for the VC0 register bank ports.
// Assumes one hclk domain and the bank's zero-wait bus timing.
`timescale 1ns/1ps
module vca_regs_assertions (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bus
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Preset and arbiter side
   input wire logic preset_map_valid,
   input wire logic [7:0] preset_map,
   input wire vca_pkg::vca_ctrl_t ctrl,
   input wire vca_pkg::vca_load_t load_pulse,
   input wire logic vc_tbl_wr,
   input wire logic [31:0] vc_tbl_wdata,
   input wire logic port_tbl_wr,
   input wire logic [31:0] port_tbl_wdata
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   logic acc;
   logic [11:0] a;
   logic wr_ctl_ff;
   logic wr_ent_ff;
   logic wr_load_ff;
   logic wr_prt_ff;
   logic wr_pre_ff;
   assign acc = hsel & hready & htrans[1];
   assign a = haddr & vca_pkg::ADDR_MASK;
   // ----
   // Write data phases
   // ----
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ctl_ff <= 1'b0;
         wr_ent_ff <= 1'b0;
         wr_load_ff <= 1'b0;
         wr_prt_ff <= 1'b0;
         wr_pre_ff <= 1'b0;
      end else begin
         wr_ctl_ff <= acc & hwrite & (a == vca_pkg::VC0_RES_CTL_OFF);
         wr_ent_ff <= acc & hwrite & (a == vca_pkg::VC_ARB_ENTRY_OFF);
         wr_load_ff <= acc & hwrite & (a == vca_pkg::VC_ARB_LOAD_OFF);
         wr_prt_ff <= acc & hwrite & (a == vca_pkg::PORT_ARB_ENTRY_OFF);
         wr_pre_ff <= acc & hwrite & (a == vca_pkg::PRESET_MAP_OFF);
      end
   end
   a_cap_fixed: assert property (
      acc && !hwrite && a == vca_pkg::VC0_RES_CAP_OFF |=> hrdata == 32'h047f0009)
      else $error("Capability word wrong");
   a_ctl_rsvd: assert property (
      acc && !hwrite && a == vca_pkg::VC0_RES_CTL_OFF |=> (hrdata & 32'h7ff1ff00) == 32'h0)
      else $error("Control read shows fixed or reserved bits");
   a_stat_rsvd: assert property (
      acc && !hwrite && a == vca_pkg::VC_PORT_STATUS_OFF |=> (hrdata & 32'hfffeffff) == 32'h0)
      else $error("Status read shows reserved bits");
   a_sel_legal: assert property (
      ctrl.port_arb_sel == 3'h0 || ctrl.port_arb_sel == 3'h3)
      else $error("Illegal port arbitration select");
   a_ctl_write: assert property (
      wr_ctl_ff && !preset_map_valid |=> ctrl.tc_map == $past(hwdata[7:0])
      && ctrl.chan_en == $past(hwdata[31])
      && ctrl.port_arb_sel == ($past(hwdata[19:17]) == 3'h3 ? 3'h3 : 3'h0))
      else $error("Control fields not updated");
   a_port_load: assert property (
      wr_ctl_ff |=> load_pulse.port_tbl_load == $past(hwdata[16]))
      else $error("Port table load pulse wrong");
   a_vc_load: assert property (
      load_pulse.vc_tbl_load == $past(wr_load_ff && hwdata[0]))
      else $error("VC table load pulse wrong");
   a_ent_wr: assert property (
      wr_ent_ff |=> vc_tbl_wr && vc_tbl_wdata == $past(hwdata))
      else $error("Table entry write not passed on");
   a_preset_map: assert property (
      preset_map_valid && !wr_ctl_ff && !wr_pre_ff |=> ctrl.tc_map == $past(preset_map))
      else $error("Preset map not taken");
   a_prt_ent_wr: assert property (
      wr_prt_ff |=> port_tbl_wr && port_tbl_wdata == $past(hwdata))
      else $error("Port table entry write not passed on");
   a_load_rd_zero: assert property (
      acc && !hwrite && a == vca_pkg::VC_ARB_LOAD_OFF |=> hrdata == 32'h0)
      else $error("Load bit read not zero");
   a_bus_okay: assert property (
      hreadyout && !hresp)
      else $error("Bus response not ready and okay");
endmodule : vca_regs_assertions

// ==== verif/vc0_arbitration_config_regs_tb.sv ====
// Self-checking bench for the VC0 register bank.
// Assumes the bank answers with zero wait states.
`timescale 1ns/1ps
module vc0_arbitration_config_regs_tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [11:0] haddr = 12'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic pv = 1'b0;
   logic [7:0] pm = 8'h0;
   logic rd_dp = 1'b0;
   logic [31:0] hrdata;
   logic hreadyout;
   vca_pkg::vca_ctrl_t ctrl;
   logic [31:0] exp_q[$];
   logic [31:0] seed = 32'h8355;
   int error_cnt = 0;
   int check_count = 0;
   always #12.5 hclk = ~hclk;
   vca_regs u_vca_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .preset_map_valid(pv),
      .preset_map(pm), .ctrl(ctrl), .load_pulse(), .vc_tbl_wr(), .vc_tbl_wdata(),
      .port_tbl_wr(), .port_tbl_wdata());
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp32
   task automatic xfer(input logic wr, input logic [11:0] ad, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= vca_pkg::VCA_HTRANS_NONSEQ;
      haddr <= ad;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= vca_pkg::VCA_HTRANS_IDLE;
      hwdata <= d;
      rd_dp <= ~wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd_dp <= 1'b0;
   endtask : xfer
   task automatic rd(input logic [11:0] ad, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(1'b0, ad, 32'h0);
   endtask : rd
   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish
   // Read results against the oldest expectation
   always @(posedge hclk) begin
      if (rd_dp === 1'b1 && hreadyout === 1'b1) cmp32(hrdata, exp_q.pop_front());
   end
   initial begin
      repeat (5000) @(posedge hclk);
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      logic [31:0] v;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      cmp32({20'h0, ctrl}, 32'h00000ff1);
      rd(12'h14c, 32'h0);
      rd(12'h150, 32'h047f0009);
      rd(12'h154, 32'h800000ff);
      rd(12'h100, 32'h0);
      xfer(1'b1, 12'h150, 32'hffffffff);
      xfer(1'b1, 12'h14c, 32'hffffffff);
      xfer(1'b1, 12'h100, 32'hffffffff);
      rd(12'h150, 32'h047f0009);
      rd(12'h14c, 32'h0);
      for (int i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         v = seed;
         v[19:17] = 3'(i);
         v[16] = 1'b1;
         v[31] = i[0];
         xfer(1'b1, 12'h154, v);
         rd(12'h154, {v[31], 11'h0, (v[19:17] == 3'h3) ? 3'h3 : 3'h0, 9'h0, v[7:0]});
      end
      pm <= 8'h5a;
      pv <= 1'b1;
      @(posedge hclk);
      pv <= 1'b0;
      rd(12'h154, 32'h8000005a);
      xfer(1'b1, 12'h17c, 32'hffffffa5);
      rd(12'h154, 32'h800000a5);
      rd(12'h17c, 32'h000000a5);
      repeat (3) begin
         seed = lfsr(seed);
         xfer(1'b1, 12'h170, seed);
         xfer(1'b1, 12'h174, seed);
      end
      rd(12'h14c, 32'h00010000);
      xfer(1'b1, 12'h178, 32'h1);
      rd(12'h178, 32'h0);
      rd(12'h14c, 32'h00010000);
      repeat (12) @(posedge hclk);
      rd(12'h14c, 32'h0);
      rd(12'h178, 32'h0);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(12'h154, 32'h800000ff);
      @(posedge hclk);
      tally_and_finish();
   end
endmodule : vc0_arbitration_config_regs_tb
bind vca_regs vca_regs_assertions u_vca_regs_assertions (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .preset_map_valid(preset_map_valid),
   .preset_map(preset_map), .ctrl(ctrl), .load_pulse(load_pulse), .vc_tbl_wr(vc_tbl_wr),
   .vc_tbl_wdata(vc_tbl_wdata), .port_tbl_wr(port_tbl_wr), .port_tbl_wdata(port_tbl_wdata));
